//--- common/ctt_cnt_if.sv
// interface: busy counter handshake between the executor and its cycle counter
`timescale 1ns/1ns
`default_nettype none
interface ctt_cnt_if;
	logic start;
	logic [4:0] len;
	logic busy;
	logic last;
	modport ctrl (output start, output len, input busy, input last);
	modport cnt (input start, input len, output busy, output last);
endinterface
`default_nettype wire

//--- common/ctt_pkg.sv
// package: opcodes, flag positions, cycle counts and vector for the transfer/trap execution block
package ctt_pkg;
	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [15:0] OP_SOFTWARE_TRAP = 16'h3720;
	localparam logic [15:0] OP_SIGN_EXTEND_BYTE = 16'h27F8;
	localparam logic [15:0] OP_LOAD_MODULO_MASKS = 16'h372F;
	localparam logic [15:0] OP_LOAD_ACC_FROM_PAIR = 16'h27B1;
	localparam logic [15:0] OP_READ_E_BANK = 16'h27BB;
	localparam logic [15:0] OP_LOAD_HIGH_ACC_WORD = 16'h27B2;
	localparam logic [15:0] OP_A_TO_B = 16'h3717;
	localparam logic [15:0] OP_B_TO_A = 16'h3707;
	localparam logic [15:0] OP_D_TO_E = 16'h277B;
	localparam logic [15:0] OP_E_TO_D = 16'h27FB;
	localparam logic [15:0] OP_A_TO_FLAGS = 16'h37FD;
	localparam logic [15:0] OP_D_TO_FLAGS = 16'h372D;
	localparam logic [15:0] OP_B_TO_EBANK = 16'h27FA;
	localparam logic [15:0] OP_B_TO_STACK_BANK = 16'h379F;
	// ----------------------------------------------------------------
	// condition flag bit positions
	// ----------------------------------------------------------------
	localparam int FLAG_C = 8;
	localparam int FLAG_V = 9;
	localparam int FLAG_Z = 10;
	localparam int FLAG_N = 11;
	localparam int FLAG_ACC_EXT = 12;
	localparam int FLAG_ACC_OVF = 14;
	// ----------------------------------------------------------------
	// cycle counts and constants
	// ----------------------------------------------------------------
	localparam logic [4:0] CYC_TRAP = 5'h10;
	localparam logic [4:0] CYC_SHORT = 5'h02;
	localparam logic [4:0] CYC_LONG = 5'h04;
	localparam logic [15:0] PTR_STEP = 16'h0002;
	localparam logic [15:0] TRAP_VECTOR_RST = 16'h0000;
	localparam logic [15:0] FLAGS_RST = 16'h0000;
	localparam logic [15:0] SP_RST = 16'h0000;
	localparam logic [3:0] BANK_RST = 4'h0;
	// ----------------------------------------------------------------
	// trap sequence states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_PUSH_PC = 6'h02,
		ST_DEC1 = 6'h04,
		ST_PUSH_FLAGS = 6'h08,
		ST_DEC2 = 6'h10,
		ST_VECTOR = 6'h20
	} ctt_state_type;
endpackage

//--- logic/ctt_cycle_counter.sv
// module: counts the cycles an instruction occupies
`timescale 1ns/1ns
`default_nettype none
module ctt_cycle_counter
	import ctt_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	ctt_cnt_if.cnt c
);
	logic [4:0] left_q;

	// load on start, count down to zero; busy while cycles remain
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			left_q <= 5'h00;
		end else if (c.start) begin
			left_q <= c.len - 5'h01;
		end else if (left_q != 5'h00) begin
			left_q <= left_q - 5'h01;
		end
	end
	assign c.busy = (left_q != 5'h00);
	assign c.last = (left_q == 5'h01);
endmodule
`default_nettype wire

//--- logic/ctt_exec.sv
// module: executes trap, sign-extend and register transfer instructions
`timescale 1ns/1ns
`default_nettype none
// Operation
// - trap first adds two to bank:counter, then pushes the counter
// - trap then steps stack, pushes flags, steps stack, clears bank, loads vector; 16 cycles
// - sign-extend fills A from B bit 7 in 2 cycles; only N and Z change
// - load masks: D high to X mask, D low to Y mask, 2 cycles, no flags
// - load accumulator from E:D, sign bits from bit 31, clear accumulator flags, 4 cycles
// - read E bank into B low nibble, high nibble zero, 2 cycles, no flags
// - load E to accumulator high word, clear low word, sign extend, clear accumulator flags, 4 cycles
module ctt_exec
	import ctt_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic issue_i,
	input wire logic [15:0] opcode_i,
	input wire logic [15:0] trap_vector_i,
	output logic ready_o,
	output logic done_o,
	output logic [7:0] acc_a_o,
	output logic [7:0] acc_b_o,
	output logic [15:0] acc_e_o,
	output logic [15:0] condition_flags_o,
	output logic [3:0] program_bank_o,
	output logic [15:0] pc_o,
	output logic [3:0] stack_bank_o,
	output logic [15:0] sp_o,
	output logic [3:0] extension_bank_e_o,
	output logic [7:0] x_modulo_mask_o,
	output logic [7:0] y_modulo_mask_o,
	output logic [35:0] mac_accumulator_o,
	output logic push_o,
	output logic [19:0] push_addr_o,
	output logic [15:0] push_data_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ctt_cnt_if cnt_bus();
	ctt_state_type state_q;
	logic [7:0] a_q, b_q;
	logic [15:0] e_q, flags_q, pc_q, sp_q, push_data_q;
	logic [3:0] prog_bank_q, stk_bank_q, ebank_q;
	logic [7:0] xm_q, ym_q;
	logic [35:0] mac_q;
	logic push_q, done_q, ready_q;
	logic [19:0] push_addr_q;
	logic take;
	logic [15:0] d_w;

	assign d_w = {a_q, b_q};
	// ready_q also covers the done cycle, so a request there is refused as well
	assign take = issue_i && ready_q && state_q == ST_IDLE;

	ctt_cycle_counter u_cnt (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.c(cnt_bus)
	);

	// instruction length chosen from the opcode; unknown opcodes take 2 cycles as no-ops
	always_comb begin
		cnt_bus.start = take;
		if (opcode_i == OP_SOFTWARE_TRAP) begin
			cnt_bus.len = CYC_TRAP;
		end else if (opcode_i == OP_LOAD_ACC_FROM_PAIR || opcode_i == OP_LOAD_HIGH_ACC_WORD) begin
			cnt_bus.len = CYC_LONG;
		end else if (opcode_i == OP_A_TO_FLAGS || opcode_i == OP_D_TO_FLAGS) begin
			cnt_bus.len = CYC_LONG;
		end else begin
			cnt_bus.len = CYC_SHORT;
		end
	end

	// ----------------------------------------------------------------
	// trap sequencer
	// ----------------------------------------------------------------
	// steps run back to back, then the sequencer idles until the counter ends
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (take && opcode_i == OP_SOFTWARE_TRAP) begin
						state_q <= ST_PUSH_PC;
					end
				end
				ST_PUSH_PC: state_q <= ST_DEC1;
				ST_DEC1: state_q <= ST_PUSH_FLAGS;
				ST_PUSH_FLAGS: state_q <= ST_DEC2;
				ST_DEC2: state_q <= ST_VECTOR;
				ST_VECTOR: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// program bank:counter and stack pointer updates of the trap
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_bank_q <= BANK_RST;
			pc_q <= TRAP_VECTOR_RST;
			sp_q <= SP_RST;
		end else if (take && opcode_i == OP_SOFTWARE_TRAP) begin
			{prog_bank_q, pc_q} <= {prog_bank_q, pc_q} + {4'h0, PTR_STEP};
		end else if (state_q == ST_DEC1 || state_q == ST_DEC2) begin
			sp_q <= sp_q - PTR_STEP;
		end else if (state_q == ST_VECTOR) begin
			prog_bank_q <= BANK_RST;
			pc_q <= trap_vector_i;
		end
	end

	// stack bank: bank transfer, or decrement on borrow out of the stack pointer step
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stk_bank_q <= BANK_RST;
		end else if (take && opcode_i == OP_B_TO_STACK_BANK) begin
			stk_bank_q <= b_q[3:0];
		end else if ((state_q == ST_DEC1 || state_q == ST_DEC2) && sp_q < PTR_STEP) begin
			stk_bank_q <= stk_bank_q - 4'h1;
		end
	end

	// stack writes: counter first, then flags
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			push_q <= 1'b0;
			push_addr_q <= 20'h00000;
			push_data_q <= 16'h0000;
		end else begin
			push_q <= (state_q == ST_PUSH_PC) || (state_q == ST_PUSH_FLAGS);
			push_addr_q <= {stk_bank_q, sp_q};
			push_data_q <= (state_q == ST_PUSH_PC) ? pc_q : flags_q;
		end
	end

	// ----------------------------------------------------------------
	// data registers
	// ----------------------------------------------------------------
	// accumulators a, b and e
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a_q <= 8'h00;
			b_q <= 8'h00;
			e_q <= 16'h0000;
		end else if (take) begin
			if (opcode_i == OP_SIGN_EXTEND_BYTE) begin
				a_q <= b_q[7] ? 8'hFF : 8'h00;
			end else if (opcode_i == OP_READ_E_BANK) begin
				b_q <= {4'h0, ebank_q};
			end else if (opcode_i == OP_A_TO_B) begin
				b_q <= a_q;
			end else if (opcode_i == OP_B_TO_A) begin
				a_q <= b_q;
			end else if (opcode_i == OP_D_TO_E) begin
				e_q <= d_w;
			end else if (opcode_i == OP_E_TO_D) begin
				{a_q, b_q} <= e_q;
			end
		end
	end

	// condition flags; transfers that do not name a flag leave it alone
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_q <= FLAGS_RST;
		end else if (take) begin
			if (opcode_i == OP_SIGN_EXTEND_BYTE) begin
				flags_q[FLAG_N] <= b_q[7];
				flags_q[FLAG_Z] <= !b_q[7];
			end else if (opcode_i == OP_A_TO_B || opcode_i == OP_B_TO_A) begin
				flags_q[FLAG_N] <= (opcode_i == OP_A_TO_B) ? a_q[7] : b_q[7];
				flags_q[FLAG_Z] <= (opcode_i == OP_A_TO_B) ? (a_q == 8'h00) : (b_q == 8'h00);
				flags_q[FLAG_V] <= 1'b0;
			end else if (opcode_i == OP_D_TO_E || opcode_i == OP_E_TO_D) begin
				flags_q[FLAG_N] <= (opcode_i == OP_D_TO_E) ? d_w[15] : e_q[15];
				flags_q[FLAG_Z] <= (opcode_i == OP_D_TO_E) ? (d_w == 16'h0000) : (e_q == 16'h0000);
				flags_q[FLAG_V] <= 1'b0;
			end else if (opcode_i == OP_A_TO_FLAGS) begin
				flags_q[15:8] <= a_q;
			end else if (opcode_i == OP_D_TO_FLAGS) begin
				flags_q[15:4] <= d_w[15:4];
			end else if (opcode_i == OP_LOAD_ACC_FROM_PAIR || opcode_i == OP_LOAD_HIGH_ACC_WORD) begin
				flags_q[FLAG_ACC_OVF] <= 1'b0;
				flags_q[FLAG_ACC_EXT] <= 1'b0;
			end
		end
	end

	// banks, masks and mac accumulator
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ebank_q <= BANK_RST;
			xm_q <= 8'h00;
			ym_q <= 8'h00;
			mac_q <= 36'h000000000;
		end else if (take) begin
			if (opcode_i == OP_LOAD_MODULO_MASKS) begin
				xm_q <= d_w[15:8];
				ym_q <= d_w[7:0];
			end else if (opcode_i == OP_LOAD_ACC_FROM_PAIR) begin
				mac_q <= {{4{e_q[15]}}, e_q, d_w};
			end else if (opcode_i == OP_LOAD_HIGH_ACC_WORD) begin
				mac_q <= {{4{e_q[15]}}, e_q, 16'h0000};
			end else if (opcode_i == OP_B_TO_EBANK) begin
				ebank_q <= b_q[3:0];
			end
		end
	end

	// ready and completion pulse; ready is a flop so the port has no logic behind it
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_q <= 1'b0;
			ready_q <= 1'b1;
		end else begin
			done_q <= cnt_bus.last;
			ready_q <= !take && !cnt_bus.busy; // last implies busy, so the done cycle stays closed
		end
	end

	assign ready_o = ready_q;
	assign done_o = done_q;
	assign acc_a_o = a_q;
	assign acc_b_o = b_q;
	assign acc_e_o = e_q;
	assign condition_flags_o = flags_q;
	assign program_bank_o = prog_bank_q;
	assign pc_o = pc_q;
	assign stack_bank_o = stk_bank_q;
	assign sp_o = sp_q;
	assign extension_bank_e_o = ebank_q;
	assign x_modulo_mask_o = xm_q;
	assign y_modulo_mask_o = ym_q;
	assign mac_accumulator_o = mac_q;
	assign push_o = push_q;
	assign push_addr_o = push_addr_q;
	assign push_data_o = push_data_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_trap_steps;
		state_q == ST_PUSH_PC ##1 state_q == ST_DEC1 ##1 state_q == ST_PUSH_FLAGS ##1 state_q == ST_DEC2;
	endsequence

	a_trap_pc_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_SOFTWARE_TRAP |=> pc_q == $past(pc_q) + PTR_STEP)
		else $error("trap did not advance counter by two");
	a_trap_order: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_SOFTWARE_TRAP |=> s_trap_steps ##1 state_q == ST_VECTOR ##1 prog_bank_q == BANK_RST)
		else $error("trap step order wrong");
	a_trap_length: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_SOFTWARE_TRAP |=> cnt_bus.busy && !cnt_bus.last ##13 cnt_bus.busy && !cnt_bus.last
		##1 cnt_bus.last ##1 !cnt_bus.busy)
		else $error("trap not 16 cycles");
	a_sxt_fill: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_SIGN_EXTEND_BYTE |=> a_q == {8{$past(b_q[7])}} && flags_q[FLAG_V] == $past(flags_q[FLAG_V]))
		else $error("sign extend wrong");
	a_mask_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_LOAD_MODULO_MASKS |=> {xm_q, ym_q} == $past(d_w) && $stable(flags_q))
		else $error("mask load wrong");
	a_acc_pair: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_LOAD_ACC_FROM_PAIR |=> mac_q[31:0] == {$past(e_q), $past(d_w)} && !flags_q[FLAG_ACC_OVF]
		##1 cnt_bus.busy ##1 cnt_bus.busy ##1 !cnt_bus.busy)
		else $error("accumulator pair load wrong");
	a_ebank_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_READ_E_BANK |=> b_q == {4'h0, $past(ebank_q)} && $stable(flags_q))
		else $error("e bank read wrong");
	a_acc_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_LOAD_HIGH_ACC_WORD |=> mac_q == {{4{$past(e_q[15])}}, $past(e_q), 16'h0000}
		&& !flags_q[FLAG_ACC_EXT])
		else $error("high word load wrong");
	a_plain_xfer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		take && opcode_i == OP_A_TO_B |=> b_q == $past(a_q) && !flags_q[FLAG_V] ##1 !cnt_bus.busy)
		else $error("plain transfer wrong");
endmodule
`default_nettype wire

//--- verification/tb.sv
// testbench: drives the transfer and trap executor and compares it with a behavioural model
`timescale 1ns/1ns
`default_nettype none
module tb;
	import ctt_pkg::*;
	logic mclk_i;
	logic rst_n_i;
	logic issue_i;
	logic [15:0] opcode_i;
	logic [15:0] trap_vector_i;
	logic ready_o, done_o, push_o;
	logic [7:0] acc_a_o, acc_b_o, x_modulo_mask_o, y_modulo_mask_o;
	logic [15:0] acc_e_o, condition_flags_o, pc_o, sp_o, push_data_o;
	logic [3:0] program_bank_o, stack_bank_o, extension_bank_e_o;
	logic [35:0] mac_accumulator_o;
	logic [19:0] push_addr_o;
	// model state, kept in the same widths as the outputs
	logic [7:0] m_a, m_b, m_xm, m_ym;
	logic [15:0] m_e, m_fl, m_pc, m_sp;
	logic [3:0] m_pbank, m_sbank, m_ebank;
	logic [35:0] m_mac;
	logic [35:0] push_q[$];
	logic [15:0] ops[15];
	int num_errors;
	int comparisons;
	int seed;
	int i;
	ctt_exec i_ctt_exec (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .opcode_i(opcode_i),
		.trap_vector_i(trap_vector_i), .ready_o(ready_o), .done_o(done_o), .acc_a_o(acc_a_o),
		.acc_b_o(acc_b_o), .acc_e_o(acc_e_o), .condition_flags_o(condition_flags_o),
		.program_bank_o(program_bank_o), .pc_o(pc_o), .stack_bank_o(stack_bank_o), .sp_o(sp_o),
		.extension_bank_e_o(extension_bank_e_o), .x_modulo_mask_o(x_modulo_mask_o),
		.y_modulo_mask_o(y_modulo_mask_o), .mac_accumulator_o(mac_accumulator_o), .push_o(push_o),
		.push_addr_o(push_addr_o), .push_data_o(push_data_o));
	// ----------------------------------------------------------------
	// clock, reporting
	// ----------------------------------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	task automatic stop_test();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	// stack writes are checked mid-cycle, when the registered pulse has settled
	always @(negedge mclk_i) begin
		if (push_o === 1'b1) begin
			if (push_q.size() == 0) begin
				chk(1'b0, "unexpected stack write");
			end else begin
				chk({push_addr_o, push_data_o} === push_q.pop_front(), "stack write");
			end
		end
	end
	task automatic model_reset();
		{m_a, m_b, m_e, m_fl, m_pbank, m_pc, m_sbank, m_sp, m_ebank, m_xm, m_ym, m_mac} = '0;
		push_q.delete();
	endtask
	// ----------------------------------------------------------------
	// one instruction: issue, model, count cycles, compare
	// ----------------------------------------------------------------
	task automatic exec(input logic [15:0] op, input logic noise);
		int k;
		int n;
		int len;
		logic r;
		logic ok;
		logic [19:0] bank_pc;
		@(posedge mclk_i);
		issue_i <= 1'b1;
		opcode_i <= op;
		trap_vector_i <= 16'($random(seed));
		k = 0;
		do begin
			@(negedge mclk_i);
			r = ready_o;
			@(posedge mclk_i);
			k++;
		end while (r !== 1'b1 && k < 40);
		issue_i <= 1'b0;
		if (k >= 40) begin
			num_errors++;
			$display("BAD %0t request never taken", $time);
			stop_test();
		end
		len = 2;
		case (op)
			OP_SOFTWARE_TRAP: begin
				len = 16;
				bank_pc = {m_pbank, m_pc} + 20'h00002;
				{m_pbank, m_pc} = bank_pc;
				push_q.push_back({m_sbank, m_sp, m_pc});
				// the stack step is on the 20-bit bank:pointer pair, so a borrow reaches the bank
				{m_sbank, m_sp} = {m_sbank, m_sp} - 20'h00002;
				push_q.push_back({m_sbank, m_sp, m_fl});
				{m_sbank, m_sp} = {m_sbank, m_sp} - 20'h00002;
				m_pbank = 4'h0;
				m_pc = trap_vector_i;
			end
			OP_SIGN_EXTEND_BYTE: begin
				m_a = m_b[7] ? 8'hFF : 8'h00;
				m_fl[FLAG_N] = m_a[7];
				m_fl[FLAG_Z] = (m_a == 8'h00);
			end
			OP_LOAD_MODULO_MASKS: {m_xm, m_ym} = {m_a, m_b};
			OP_LOAD_ACC_FROM_PAIR, OP_LOAD_HIGH_ACC_WORD: begin
				len = 4;
				m_mac = {{4{m_e[15]}}, m_e, (op == OP_LOAD_ACC_FROM_PAIR) ? {m_a, m_b} : 16'h0000};
				m_fl[FLAG_ACC_OVF] = 1'b0;
				m_fl[FLAG_ACC_EXT] = 1'b0;
			end
			OP_READ_E_BANK: m_b = {4'h0, m_ebank};
			OP_A_TO_B, OP_B_TO_A: begin
				if (op == OP_A_TO_B) m_b = m_a;
				else m_a = m_b;
				m_fl[FLAG_N] = m_a[7];
				m_fl[FLAG_Z] = (m_a == 8'h00);
				m_fl[FLAG_V] = 1'b0;
			end
			OP_D_TO_E, OP_E_TO_D: begin
				if (op == OP_D_TO_E) m_e = {m_a, m_b};
				else {m_a, m_b} = m_e;
				m_fl[FLAG_N] = m_e[15];
				m_fl[FLAG_Z] = (m_e == 16'h0000);
				m_fl[FLAG_V] = 1'b0;
			end
			OP_A_TO_FLAGS: begin
				len = 4;
				m_fl[15:8] = m_a;
			end
			OP_D_TO_FLAGS: begin
				len = 4;
				m_fl[15:4] = {m_a, m_b[7:4]};
			end
			OP_B_TO_EBANK: m_ebank = m_b[3:0];
			OP_B_TO_STACK_BANK: m_sbank = m_b[3:0];
			default: len = 2;
		endcase
		#1;
		ok = (ready_o === 1'b0);
		n = 0;
		while (done_o !== 1'b1 && n < 40) begin
			@(posedge mclk_i);
			// junk requests while busy must be refused
			issue_i <= noise && (n + 1 < len);
			opcode_i <= 16'($random(seed));
			n++;
			#1;
			if (done_o !== 1'b1) ok = ok && (ready_o === 1'b0);
		end
		if (n >= 40) begin
			num_errors++;
			$display("BAD %0t no done pulse", $time);
			stop_test();
		end
		// the take edge is the first of len busy-or-done cycles, so done shows len - 1 edges later
		ok = ok && (n == len - 1) && (ready_o === 1'b0) && (push_q.size() == 0);
		ok = ok && ({acc_a_o, acc_b_o, acc_e_o, condition_flags_o, program_bank_o, pc_o, stack_bank_o, sp_o,
			extension_bank_e_o, x_modulo_mask_o, y_modulo_mask_o, mac_accumulator_o} ===
			{m_a, m_b, m_e, m_fl, m_pbank, m_pc, m_sbank, m_sp, m_ebank, m_xm, m_ym, m_mac});
		case (op)
			OP_SOFTWARE_TRAP: chk(ok, "trap result");
			OP_SIGN_EXTEND_BYTE: chk(ok, "sign extend result");
			OP_LOAD_MODULO_MASKS: chk(ok, "mask load result");
			OP_LOAD_ACC_FROM_PAIR: chk(ok, "pair load result");
			OP_READ_E_BANK: chk(ok, "bank read result");
			OP_LOAD_HIGH_ACC_WORD: chk(ok, "high word load result");
			default: chk(ok, "transfer result");
		endcase
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		ops = '{OP_SOFTWARE_TRAP, OP_SIGN_EXTEND_BYTE, OP_LOAD_MODULO_MASKS, OP_LOAD_ACC_FROM_PAIR, OP_READ_E_BANK,
			OP_LOAD_HIGH_ACC_WORD, OP_A_TO_B, OP_B_TO_A, OP_D_TO_E, OP_E_TO_D, OP_A_TO_FLAGS, OP_D_TO_FLAGS,
			OP_B_TO_EBANK, OP_B_TO_STACK_BANK, 16'hFFFF};
		num_errors = 0;
		comparisons = 0;
		seed = 67032;
		rst_n_i = 1'b0;
		issue_i = 1'b0;
		opcode_i = 16'h0000;
		trap_vector_i = 16'h0000;
		model_reset();
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		// every opcode once, in table order, then back-to-back traps
		for (i = 0; i < 15; i++) begin
			exec(ops[i], 1'b0);
		end
		exec(OP_SOFTWARE_TRAP, 1'b1);
		exec(OP_SOFTWARE_TRAP, 1'b0);
		// random mix with refused requests during busy cycles
		for (i = 0; i < 80; i++) begin
			exec(ops[$unsigned($random(seed)) % 15], 1'b1);
		end
		// reset in mid-run clears state and reopens the request path; junk requests are dropped at the same edge
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		issue_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk(ready_o === 1'b1 && pc_o === 16'h0000 && sp_o === 16'h0000 && condition_flags_o === 16'h0000,
			"reset state");
		model_reset();
		@(posedge mclk_i);
		rst_n_i <= 1'b1;
		exec(OP_SOFTWARE_TRAP, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
